// ===== hw/pwm4_core.v
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
`include "pwm4_defines.vh"
module pwm4_core #(
    parameter CHANNELS = 4,
    parameter CNT_W = 10,
    parameter PRESCALE_W = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [CHANNELS-1:0] pwm_out
);

// ==========================================
// holding, working and control state
// software only ever touches the hold copies; the compare stage reads the
// working copies and the counter reloads from the working period, or from the hold period at a load underflow, so a half-written 10-bit
// value (low byte done, high bits not yet) never reaches an output.
// the working copies change only at an underflow with load pending.
reg [CNT_W-1:0] period_hold_reg;
reg [CNT_W-1:0] period_work_reg;
reg [CNT_W*CHANNELS-1:0] cmp_hold_reg;
reg [CNT_W*CHANNELS-1:0] cmp_work_reg;
reg [CNT_W-1:0] count_reg;
reg [PRESCALE_W-1:0] prescale_reg;
reg [PRESCALE_W-1:0] prediv_reg;
reg run_reg;
reg load_reg;
reg uflow_reg;
reg clear_reg;
reg [CHANNELS-1:0] inv_reg;
reg [CHANNELS-1:0] raw_reg;
reg [31:0] aw_addr_reg;
reg aw_have_reg;
reg [31:0] w_data_reg;
reg [3:0] w_strb_reg;
reg w_have_reg;

reg wr_map;

// tick marks the clocks on which the counter moves; with prescaler n it
// comes every n+1 clocks, and never while run is clear.
// underflow is a tick seen at count zero, so zero is a step of its own
// and a period lasts the period value plus one ticks.
wire tick = run_reg && (prediv_reg == prescale_reg);
wire underflow = tick && (count_reg == {CNT_W{1'b0}});
wire [7:0] wr_idx = aw_addr_reg[9:2];
wire wr_ok = wr_map && (aw_addr_reg[31:10] == 22'h000000) && (aw_addr_reg[1:0] == 2'b00);
wire do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
wire wr_lo = w_strb_reg[0];

// ==========================================
// write decode: only listed indices are mapped, anything else is refused
// register map (index, byte address is four times it):
//   d1 period high bits, d9 period low byte
//   d2/da channel 0 high/low, d3/db channel 1 high/low
//   d5/dd channel 2 high/low, d6/de channel 3 high/low
//   dc main control, e0 prescaler
// main control: 7 run, 6 load, 5 underflow flag, 4 counter clear,
//   3:0 invert for channels 3 down to 0
always @* begin
    case (wr_idx)
        `PWM4_IDX_PERIOD_HIGH: wr_map = 1'b1;
        `PWM4_IDX_PERIOD_LOW: wr_map = 1'b1;
        `PWM4_IDX_DUTY0_HIGH: wr_map = 1'b1;
        `PWM4_IDX_DUTY0_LOW: wr_map = 1'b1;
        `PWM4_IDX_DUTY1_HIGH: wr_map = 1'b1;
        `PWM4_IDX_DUTY1_LOW: wr_map = 1'b1;
        `PWM4_IDX_DUTY2_HIGH: wr_map = 1'b1;
        `PWM4_IDX_DUTY2_LOW: wr_map = 1'b1;
        `PWM4_IDX_DUTY3_HIGH: wr_map = 1'b1;
        `PWM4_IDX_DUTY3_LOW: wr_map = 1'b1;
        `PWM4_IDX_MAIN_CTRL: wr_map = 1'b1;
        `PWM4_IDX_PRESCALE: wr_map = 1'b1;
        default: wr_map = 1'b0; // unmapped: ignored, answered with an error
    endcase
end

// ==========================================
// axi write channel: take address and data in either order
// the one-cycle ready pulse costs a clock per item, which is harmless
// at this register rate and keeps the take condition a simple and.
// a second write's address and data can be taken at once, but it is not
// performed until the response for the first has been accepted, so at most one response is ever pending.
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        aw_addr_reg <= 32'h00000000;
        w_data_reg <= 32'h00000000;
        w_strb_reg <= 4'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `PWM4_AXI_OKAY;
    end else begin
        // ready is a registered one-cycle pulse, so each item is taken once
        s_axi_awready <= !aw_have_reg && s_axi_awvalid && !s_axi_awready;
        s_axi_wready <= !w_have_reg && s_axi_wvalid && !s_axi_wready;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end
        if (do_write) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `PWM4_AXI_OKAY : `PWM4_AXI_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// ==========================================
// axi read channel with register read mux
// the mux looks at araddr directly; the master still holds the address
// at the handshake edge, so rdata is captured from a settled mux.
// unmapped reads return zero with an error response; misaligned or out-of-range reads get the error but still return the indexed byte.
reg [7:0] rd_byte;
reg rd_hit;
always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr[9:2])
        `PWM4_IDX_PERIOD_HIGH: rd_byte = {6'h00, period_hold_reg[9:8]};
        `PWM4_IDX_PERIOD_LOW: rd_byte = period_hold_reg[7:0];
        `PWM4_IDX_DUTY0_HIGH: rd_byte = {6'h00, cmp_hold_reg[9:8]};
        `PWM4_IDX_DUTY0_LOW: rd_byte = cmp_hold_reg[7:0];
        `PWM4_IDX_DUTY1_HIGH: rd_byte = {6'h00, cmp_hold_reg[19:18]};
        `PWM4_IDX_DUTY1_LOW: rd_byte = cmp_hold_reg[17:10];
        `PWM4_IDX_DUTY2_HIGH: rd_byte = {6'h00, cmp_hold_reg[29:28]};
        `PWM4_IDX_DUTY2_LOW: rd_byte = cmp_hold_reg[27:20];
        `PWM4_IDX_DUTY3_HIGH: rd_byte = {6'h00, cmp_hold_reg[39:38]};
        `PWM4_IDX_DUTY3_LOW: rd_byte = cmp_hold_reg[37:30];
        `PWM4_IDX_MAIN_CTRL: rd_byte = {run_reg, load_reg, uflow_reg, clear_reg, inv_reg[3:0]};
        `PWM4_IDX_PRESCALE: rd_byte = prescale_reg;
        default: begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
        end
    endcase
    if (s_axi_araddr[31:10] != 22'h000000 || s_axi_araddr[1:0] != 2'b00) begin
        rd_hit = 1'b0;
    end
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `PWM4_AXI_OKAY;
    end else begin
        s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? `PWM4_AXI_OKAY : `PWM4_AXI_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

// ==========================================
// software-written registers; reserved high bits are dropped
// only bit 0 of the strobe matters because every register is one byte.
// a write that sets clear zeroes the counter once; the bit then drops
// on its own so it cannot hold the counter at zero by accident.
always @(posedge aclk) begin
    if (!aresetn) begin
        period_hold_reg <= {CNT_W{1'b0}};
        cmp_hold_reg <= {CNT_W*CHANNELS{1'b0}};
        prescale_reg <= `PWM4_RST_PRESCALE;
        run_reg <= 1'b0;
        clear_reg <= 1'b0;
        inv_reg <= {CHANNELS{1'b0}};
    end else if (do_write && wr_ok && wr_lo) begin
        case (wr_idx)
            `PWM4_IDX_PERIOD_HIGH: period_hold_reg[9:8] <= w_data_reg[1:0];
            `PWM4_IDX_PERIOD_LOW: period_hold_reg[7:0] <= w_data_reg[7:0];
            `PWM4_IDX_DUTY0_HIGH: cmp_hold_reg[9:8] <= w_data_reg[1:0];
            `PWM4_IDX_DUTY0_LOW: cmp_hold_reg[7:0] <= w_data_reg[7:0];
            `PWM4_IDX_DUTY1_HIGH: cmp_hold_reg[19:18] <= w_data_reg[1:0];
            `PWM4_IDX_DUTY1_LOW: cmp_hold_reg[17:10] <= w_data_reg[7:0];
            `PWM4_IDX_DUTY2_HIGH: cmp_hold_reg[29:28] <= w_data_reg[1:0];
            `PWM4_IDX_DUTY2_LOW: cmp_hold_reg[27:20] <= w_data_reg[7:0];
            `PWM4_IDX_DUTY3_HIGH: cmp_hold_reg[39:38] <= w_data_reg[1:0];
            `PWM4_IDX_DUTY3_LOW: cmp_hold_reg[37:30] <= w_data_reg[7:0];
            `PWM4_IDX_MAIN_CTRL: begin
                run_reg <= w_data_reg[`PWM4_CTRL_RUN];
                clear_reg <= w_data_reg[`PWM4_CTRL_CLEAR];
                inv_reg <= w_data_reg[`PWM4_CTRL_INV_MSB:0];
            end
            `PWM4_IDX_PRESCALE: prescale_reg <= w_data_reg[PRESCALE_W-1:0];
            default: begin
            end
        endcase
    end else begin
        clear_reg <= 1'b0; // clear control acts once, then self-clears
    end
end

// ==========================================
// load and underflow flags: hardware action wins over a software write
// load is cleared by the transfer itself; software polls for the drop.
// with run clear no underflow comes, so a pending load simply waits.
wire ctrl_wr = do_write && wr_ok && wr_lo && (wr_idx == `PWM4_IDX_MAIN_CTRL);
always @(posedge aclk) begin
    if (!aresetn) begin
        load_reg <= 1'b0;
    end else if (underflow && load_reg) begin
        load_reg <= 1'b0;
    end else if (ctrl_wr) begin
        load_reg <= w_data_reg[`PWM4_CTRL_LOAD];
    end
end

// the underflow flag stands for one clock after each underflow, so a
// slow poll can miss it; load is the reliable completion signal.
// flag is plain status, no request leaves the block
always @(posedge aclk) begin
    if (!aresetn) begin
        uflow_reg <= 1'b0;
    end else if (underflow) begin
        uflow_reg <= 1'b1;
    end else if (uflow_reg || ctrl_wr) begin
        uflow_reg <= 1'b0;
    end
end

// ==========================================
// prescaler and shared down counter
// the prescaler restarts while stopped, so the first tick after run is
// set comes a full prescaler interval later, never a partial one.
always @(posedge aclk) begin
    if (!aresetn) begin
        prediv_reg <= {PRESCALE_W{1'b0}};
    end else if (!run_reg || tick) begin
        prediv_reg <= {PRESCALE_W{1'b0}};
    end else begin
        prediv_reg <= prediv_reg + {{(PRESCALE_W-1){1'b0}}, 1'b1};
    end
end

// clear has priority over everything so the start-up sequence always
// begins from a known count, even while run is already set.
always @(posedge aclk) begin
    if (!aresetn) begin
        count_reg <= {CNT_W{1'b0}};
    end else if (clear_reg) begin
        count_reg <= {CNT_W{1'b0}};
    end else if (underflow) begin
        // a pending load uses the new period straight away
        count_reg <= load_reg ? period_hold_reg : period_work_reg;
    end else if (tick) begin
        count_reg <= count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
    end
end

// period and compares move together, so the new period and the new
// compares start on the same clock and no mixed period is produced.
always @(posedge aclk) begin
    if (!aresetn) begin
        period_work_reg <= {CNT_W{1'b0}};
        cmp_work_reg <= {CNT_W*CHANNELS{1'b0}};
    end else if (underflow && load_reg) begin
        period_work_reg <= period_hold_reg;
        cmp_work_reg <= cmp_hold_reg;
    end
end

// ==========================================
// per-channel compare, special values, inversion
// outputs are registered, so each one lags the counter by one clock;
// with run clear the last raw level is kept and only inversion acts,
// which lets software flip a stopped output without restarting.
genvar ch;
generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
        wire [CNT_W-1:0] cmp = cmp_work_reg[ch*CNT_W +: CNT_W];
        reg level;
        // special values first, then the over-range case, then the plain
        // compare; all ones must win even when the period is also all ones
        always @* begin
            if (cmp == `PWM4_CMP_ZERO) begin
                level = 1'b1;
            end else if (cmp == `PWM4_CMP_ALL_ONES) begin
                level = 1'b0;
            end else if (cmp > period_work_reg) begin
                level = 1'b0;
            end else begin
                // high while counter at or above compare; reload restarts high
                level = (count_reg >= cmp);
            end
        end
        always @(posedge aclk) begin
            if (!aresetn) begin
                raw_reg[ch] <= 1'b1;
                pwm_out[ch] <= 1'b1;
            end else if (run_reg) begin
                raw_reg[ch] <= level;
                pwm_out[ch] <= level ^ inv_reg[ch];
            end else begin
                pwm_out[ch] <= raw_reg[ch] ^ inv_reg[ch];
            end
        end
    end
endgenerate

endmodule // pwm4_core

// ===== include/pwm4_defines.vh
`ifndef PWM4_DEFINES_VH
`define PWM4_DEFINES_VH
// ==========================================
// register indices (printed offsets, byte address = 4 * index)
`define PWM4_IDX_PERIOD_HIGH 8'hD1
`define PWM4_IDX_DUTY0_HIGH 8'hD2
`define PWM4_IDX_DUTY1_HIGH 8'hD3
`define PWM4_IDX_DUTY2_HIGH 8'hD5
`define PWM4_IDX_DUTY3_HIGH 8'hD6
`define PWM4_IDX_PERIOD_LOW 8'hD9
`define PWM4_IDX_DUTY0_LOW 8'hDA
`define PWM4_IDX_DUTY1_LOW 8'hDB
`define PWM4_IDX_MAIN_CTRL 8'hDC
`define PWM4_IDX_DUTY2_LOW 8'hDD
`define PWM4_IDX_DUTY3_LOW 8'hDE
`define PWM4_IDX_PRESCALE 8'hE0
// ==========================================
// main control register fields
`define PWM4_CTRL_RUN 7
`define PWM4_CTRL_LOAD 6
`define PWM4_CTRL_UFLOW 5
`define PWM4_CTRL_CLEAR 4
`define PWM4_CTRL_INV_MSB 3
// ==========================================
// reset values and special compare values
`define PWM4_RST_BYTE 8'h00
`define PWM4_RST_PRESCALE 8'h00
`define PWM4_CMP_ALL_ONES 10'h3FF
`define PWM4_CMP_ZERO 10'h000
`define PWM4_AXI_OKAY 2'b00
`define PWM4_AXI_SLVERR 2'b10
`endif

// ===== sim/pwm4_core_sva.sv
`timescale 1ns/10ps
// ====================
// bus handshake and output checks
module pwm4_core_sva (
    input wire aclk,
    input wire aresetn,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [3:0] pwm_out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // a write is two steps: address taken, then the response a few cycles on
    sequence aw_take;
        s_axi_awvalid && s_axi_awready;
    endsequence
    sequence b_wait;
        ##[0:3] s_axi_bvalid;
    endsequence
    chk_reset_all_high: assert property ($rose(aresetn) |-> pwm_out == 4'hF)
        else $error("outputs not all high after reset");
    chk_aw_one_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("write address ready held too long");
    chk_b_follows: assert property (aw_take |=> b_wait)
        else $error("no write response after address");
    chk_unmapped_err: assert property (aw_take ##0 s_axi_awaddr == 32'h0 |=> ##[0:3] s_axi_bresp == 2'b10)
        else $error("unmapped write not refused");
    chk_b_clears: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not cleared");
    chk_r_clears: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not cleared");
    chk_r_follows_ar: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("reserved read bits set");
endmodule // pwm4_core_sva
bind pwm4_core pwm4_core_sva chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .pwm_out);

// ===== sim/pwm4_load.sv
`timescale 1ns/10ps
// ====================
// output loads: a filter load sees only the average, so count high time and edges
module pwm4_load (
    input wire aclk,
    input wire meas_en,
    input wire [3:0] pwm_out,
    output int hi_cnt [4],
    output int rise_cnt [4]
);
    // the load sits on the pin and follows the output directly
    logic [3:0] last_reg;
    // counts restart whenever the window is closed
    always @(posedge aclk) begin
        last_reg <= pwm_out;
        for (int i = 0; i < 4; i++) begin
            hi_cnt[i] <= meas_en ? hi_cnt[i] + pwm_out[i] : 0;
            rise_cnt[i] <= meas_en ? rise_cnt[i] + (pwm_out[i] & ~last_reg[i]) : 0;
        end
    end
endmodule // pwm4_load

// ===== sim/pwm4_core_bench.sv
`timescale 1ns/10ps
module pwm4_core_bench;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, meas_en = 0;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rd_val;
    logic [1:0] rsp;
    logic [3:0] snap;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [3:0] pwm;
    int hi [4], rise [4];
    int fail_count = 0, n_checks = 0;
    logic [7:0] tab [10] = '{8'hD1, 8'hD2, 8'hD3, 8'hD5, 8'hD6, 8'hD9, 8'hDA, 8'hDB, 8'hDD, 8'hDE};
    logic [7:0] cfg [10] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h04, 8'h00, 8'hFF, 8'h02, 8'h07};
    // ====================
    // clock, design and loads
    initial begin
        forever #50 aclk = ~aclk;
    end
    pwm4_core dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pwm_out(pwm));
    pwm4_load load (.aclk(aclk), .meas_en(meas_en), .pwm_out(pwm), .hi_cnt(hi), .rise_cnt(rise));
    // ====================
    // reporting
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic stuck();
        fail_count++;
        $display("BAD %0t bus gave no answer", $time);
        give_verdict();
    endtask
    // ====================
    // bus tasks: each channel released at its own handshake, waits bounded
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        int n = 0;
        @(posedge aclk);
        awaddr <= {22'h0, idx, 2'b00};
        wdata <= {24'h0, val};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 40);
        rsp = bresp;
        bready <= 1'b0;
        if (n >= 40) stuck();
    endtask
    task automatic rd(input logic [7:0] idx);
        int n = 0;
        @(posedge aclk);
        araddr <= {22'h0, idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 40);
        rd_val = rdata;
        rsp = rresp;
        rready <= 1'b0;
        if (n >= 40) stuck();
    endtask
    // poll the load bit until the transfer has happened
    task automatic wait_load();
        for (int k = 0; k < 30; k++) begin
            rd(8'hDC);
            if (rd_val[6] === 1'b0) break;
        end
        expect_eq(rd_val & 32'h40, 32'h0);
    endtask
    // window of 100 clocks is a whole number of periods in every scenario
    task automatic measure(input int h0, input int h1, input int h2, input int h3, input int r2);
        repeat (3) @(posedge aclk);
        meas_en <= 1'b1;
        repeat (100) @(posedge aclk);
        meas_en <= 1'b0;
        #1;
        expect_eq(hi[0], h0);
        expect_eq(hi[1], h1);
        expect_eq(hi[2], h2);
        expect_eq(hi[3], h3);
        expect_eq(rise[2], r2);
    endtask
    // ====================
    // scenarios
    task automatic sc_regs();
        expect_eq(pwm, 4'hF);
        for (int i = 0; i < 10; i++) begin
            rd(tab[i]);
            expect_eq(rd_val, 32'h0);
            wr(tab[i], 8'hFF);
            rd(tab[i]);
            expect_eq(rd_val, i < 5 ? 32'h3 : 32'hFF);
        end
        wr(8'h00, 8'h55);
        expect_eq(rsp, 2'b10);
        rd(8'h00);
        expect_eq(rsp, 2'b10);
    endtask
    task automatic sc_run();
        wr(8'hDC, 8'h10);
        for (int i = 0; i < 10; i++) wr(tab[i], cfg[i]);
        wr(8'hDC, 8'hC0);
        wait_load();
        measure(100, 0, 60, 0, 20);
        wr(8'hE0, 8'h01);
        measure(100, 0, 60, 0, 10);
    endtask
    task automatic sc_invert_buffer();
        wr(8'hDC, 8'h85);
        measure(0, 0, 40, 0, 10);
        wr(8'hDD, 8'h04);
        measure(0, 0, 40, 0, 10);
        wr(8'hDC, 8'hC5);
        wait_load();
        measure(0, 0, 80, 0, 10);
    endtask
    task automatic sc_stop();
        wr(8'hDC, 8'h05);
        repeat (3) @(posedge aclk);
        snap = pwm;
        repeat (30) @(posedge aclk);
        expect_eq(pwm, snap);
        wr(8'hDC, 8'h45);
        repeat (30) @(posedge aclk);
        rd(8'hDC);
        expect_eq(rd_val & 32'h40, 32'h40);
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        sc_regs();
        sc_run();
        sc_invert_buffer();
        sc_stop();
        give_verdict();
    end
endmodule // pwm4_core_bench
